/* dv/ccl_core_model.sv */
// Behavioural analogue comparator core facing the comparator control logic.
// Assumes the bench supplies both input voltages in millivolts.
`timescale 1ns/1ps

module ccl_core_model (
  input  wire logic        i_enable,
  input  wire logic [15:0] i_pos_mv,
  input  wire logic [15:0] i_neg_mv,
  output logic             o_raw
);
  logic last = 1'b0;

  // ----------------------------------------------------------------
  // Compare stage
  // ----------------------------------------------------------------
  // A powered-down core gives no valid level; the inverse of the last
  // result is shown so that an ungated path in the design stands out.
  // A continuous assignment keeps the level defined from time zero.
  // positive above negative
  assign o_raw = i_enable ? (i_pos_mv > i_neg_mv) : ~last;

  // Remember the result while the core is powered
  always @(i_enable or i_pos_mv or i_neg_mv) begin
    if (i_enable) begin
      last = (i_pos_mv > i_neg_mv);
    end
  end
endmodule

/* dv/ccl_top_bench.sv */
// Self-checking bench for the comparator control logic.
// Assumes the register port contract of the top module and a core model.
`timescale 1ns/1ps
`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin num_errors++; $display("wrong value t=%0t got=%h exp=%h", $time, got, exp); end end

module ccl_top_bench;
  logic        clock = 1'b0;
  logic        clock_run = 1'b1;
  logic        arst_n, sfr_wr, sys_irq_en, rst_src_en;
  logic [7:0]  sfr_addr, sfr_wdata, rdata, rv;
  logic [15:0] pos_mv, neg_mv;
  logic        raw_in, raw_out, latched, irq, wake, rst_req, comp_en;
  logic [1:0]  hyp, hyn, resp, h;
  logic [3:0]  nsel, psel;
  int          num_errors = 0;
  int          num_checks = 0;

  // Clock can be stopped to show the raw path needs no clock
  always #2 clock = clock_run ? ~clock : clock;

  ccl_top i_ccl_top (
    .I_CLOCK(clock), .I_ARST_N(arst_n), .I_RAW_COMPARE(raw_in), .I_SFR_ADDR(sfr_addr),
    .I_SFR_WR(sfr_wr), .I_SFR_WDATA(sfr_wdata), .I_SYS_IRQ_ENABLE(sys_irq_en),
    .I_RESET_SRC_ENABLE(rst_src_en), .O_SFR_RDATA(rdata), .O_RAW_COMPARE_OUT(raw_out),
    .O_LATCHED_COMPARE_OUT(latched), .O_IRQ(irq), .O_OSC_WAKE(wake), .O_RESET_REQ(rst_req),
    .O_COMP_ENABLE(comp_en), .O_POS_HYSTERESIS_SEL(hyp), .O_NEG_HYSTERESIS_SEL(hyn),
    .O_RESPONSE_MODE(resp), .O_NEG_INPUT_SELECT(nsel), .O_POS_INPUT_SELECT(psel));

  ccl_core_model i_ccl_core_model (
    .i_enable(comp_en), .i_pos_mv(pos_mv), .i_neg_mv(neg_mv), .o_raw(raw_in));

  // ----------------------------------------------------------------
  // Access, wait and report tasks
  // ----------------------------------------------------------------
  task automatic conclude;
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // One-cycle strobe, released at the edge that took the write
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    sfr_addr  <= a;
    sfr_wdata <= d;
    sfr_wr    <= 1'b1;
    @(posedge clock);
    sfr_wr <= 1'b0;
  endtask

  // Read data is registered, so sample it one edge after the address
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock);
    sfr_addr <= a;
    @(posedge clock);
    @(negedge clock);
    d = rdata;
  endtask

  // Bounded wait on the synchronised output
  task automatic wait_latched(input logic v);
    int k;
    for (k = 0; k < 8 && latched !== v; k++) @(negedge clock);
    if (latched !== v) begin
      num_errors++;
      $display("wrong value t=%0t got=%h exp=%h", $time, latched, v);
      conclude();
    end
  endtask

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    arst_n = 1'b0; sfr_wr = 1'b0; sfr_addr = 8'h00; sfr_wdata = 8'h00;
    sys_irq_en = 1'b1; rst_src_en = 1'b1; pos_mv = 16'h0064; neg_mv = 16'h00C8;
    repeat (10) @(posedge clock);
    arst_n <= 1'b1;
    @(negedge clock);
    `CHK(comp_en, 1'b0);
    // The powered-down core shows a high level here, so this proves the gate
    `CHK({raw_out, latched}, 2'h0);
    `CHK({resp, nsel, psel}, 10'h277);
    rd(ccl_pkg::CTRL_ADDR, rv); `CHK(rv, 8'h00);
    rd(ccl_pkg::MODE_ADDR, rv); `CHK(rv, 8'h02);
    rd(ccl_pkg::MUX_ADDR, rv); `CHK(rv, 8'h77);
    wr(8'hA0, 8'hFF);
    rd(8'hA0, rv); `CHK(rv, 8'h00);
    $display("test reset values done");
    // Every hysteresis code; bit 6 written high must not stick
    for (int i = 0; i < 4; i++) begin
      h = i[1:0];
      wr(ccl_pkg::CTRL_ADDR, {4'h4, h, ~h});
      @(negedge clock);
      `CHK(hyp, h);
      `CHK(hyn, ~h);
      rd(ccl_pkg::CTRL_ADDR, rv); `CHK(rv, {4'h0, h, ~h});
    end
    wr(ccl_pkg::MUX_ADDR, 8'h5A);
    rd(ccl_pkg::MUX_ADDR, rv); `CHK(rv, 8'h5A);
    `CHK({nsel, psel}, 8'h5A);
    wr(ccl_pkg::MODE_ADDR, 8'hFF);
    rd(ccl_pkg::MODE_ADDR, rv); `CHK(rv, 8'h33);
    `CHK(resp, 2'h3);
    $display("test fields done");
    wr(ccl_pkg::CTRL_ADDR, 8'h80);
    repeat (4) @(posedge clock);
    wr(ccl_pkg::CTRL_ADDR, 8'h80);
    rd(ccl_pkg::CTRL_ADDR, rv); `CHK(rv, 8'h80);
    `CHK(comp_en, 1'b1);
    `CHK(wake, 1'b1);
    `CHK(rst_req, 1'b1);
    // Reset request must follow its own enable as well
    @(posedge clock) rst_src_en <= 1'b0;
    @(posedge clock);
    @(negedge clock);
    `CHK(rst_req, 1'b0);
    @(posedge clock) rst_src_en <= 1'b1;
    @(posedge clock) pos_mv <= 16'h012C;
    wait_latched(1'b1);
    `CHK(raw_out, 1'b1);
    repeat (2) @(posedge clock);
    rd(ccl_pkg::CTRL_ADDR, rv); `CHK(rv, 8'hE0);
    `CHK(irq, 1'b1);
    `CHK({wake, rst_req}, 2'h0);
    @(posedge clock) pos_mv <= 16'h0064;
    wait_latched(1'b0);
    repeat (2) @(posedge clock);
    rd(ccl_pkg::CTRL_ADDR, rv); `CHK(rv, 8'hB0);
    wr(ccl_pkg::CTRL_ADDR, 8'h80);
    rd(ccl_pkg::CTRL_ADDR, rv); `CHK(rv, 8'h80);
    `CHK(irq, 1'b0);
    @(posedge clock) sys_irq_en <= 1'b0;
    pos_mv <= 16'h012C;
    wait_latched(1'b1);
    repeat (2) @(posedge clock);
    rd(ccl_pkg::CTRL_ADDR, rv); `CHK(rv, 8'hE0);
    `CHK(irq, 1'b0);
    // Rise flag still set: system enable back on, rising enable off
    wr(ccl_pkg::MODE_ADDR, 8'h13);
    @(posedge clock) sys_irq_en <= 1'b1;
    @(posedge clock);
    @(negedge clock);
    `CHK(irq, 1'b0);
    $display("test edges done");
    // Clock stopped low: only the raw path may follow the inputs
    clock_run = 1'b0;
    // Already at a falling edge: waiting for another would hang with the clock stopped
    #1;
    pos_mv = 16'h0064;
    #10 `CHK(raw_out, 1'b0);
    pos_mv = 16'h012C;
    #10 `CHK(raw_out, 1'b1);
    clock_run = 1'b1;
    $display("test stopped clock done");
    wr(ccl_pkg::CTRL_ADDR, 8'h00);
    wait_latched(1'b0);
    `CHK({raw_out, comp_en, wake, rst_req}, 4'h0);
    $display("test disable done");
    conclude();
  end
endmodule

/* hw/ccl_edge_flags.sv */
// Pair of sticky edge flags: hardware sets, software writes.
// Assumes set pulses and the write strobe come from the same clock domain.
`timescale 1ns/1ps

module ccl_edge_flags (
  input  wire logic                      i_clock,
  input  wire logic                      i_arst_n,
  input  wire logic [ccl_pkg::FLAG_NUM-1:0] i_set,
  input  wire logic                      i_wr,
  input  wire logic [ccl_pkg::FLAG_NUM-1:0] i_wdata,
  output logic      [ccl_pkg::FLAG_NUM-1:0] o_flag
);

  logic [ccl_pkg::FLAG_NUM-1:0] next_flag;

  // ----------------------------------------------------------------
  // Flag update, one copy per flag
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < ccl_pkg::FLAG_NUM; g++) begin : g_flag
      always_comb begin
        if (i_set[g]) begin
          next_flag[g] = 1'b1;
        end else if (i_wr) begin
          next_flag[g] = i_wdata[g];
        end else begin
          next_flag[g] = o_flag[g];
        end
      end
    end
  endgenerate

  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_flag <= '0;
    end else begin
      o_flag <= next_flag;
    end
  end

endmodule

/* hw/ccl_pkg.sv */
// Package for the comparator control logic: register map, field layout, reset values.
// Assumes an 8-bit special function register port driven by the processor core.
package ccl_pkg;

  // ----------------------------------------------------------------
  // Register addresses on the special function register port
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_ADDR = 8'h9B;  // comparator_control_reg
  localparam logic [7:0] MODE_ADDR = 8'h9D;  // response_mode_reg
  localparam logic [7:0] MUX_ADDR  = 8'h9F;  // input_mux_reg

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] MODE_RESET = 8'h02;
  localparam logic [7:0] MUX_RESET  = 8'h77;
  localparam logic [7:0] ZERO_BYTE  = 8'h00;

  // ----------------------------------------------------------------
  // Control register bit positions
  // ----------------------------------------------------------------
  localparam int CTRL_EN_BIT   = 7;
  localparam int CTRL_OUT_BIT  = 6;
  localparam int CTRL_RISE_BIT = 5;
  localparam int CTRL_FALL_BIT = 4;
  localparam int CTRL_HYP_HI   = 3;
  localparam int CTRL_HYP_LO   = 2;
  localparam int CTRL_HYN_HI   = 1;
  localparam int CTRL_HYN_LO   = 0;

  // ----------------------------------------------------------------
  // Mode and mux register bit positions
  // ----------------------------------------------------------------
  localparam int MODE_RIE_BIT = 5;
  localparam int MODE_FIE_BIT = 4;
  localparam int MODE_MD_HI   = 1;
  localparam int MODE_MD_LO   = 0;
  localparam int MUX_NEG_HI   = 7;
  localparam int MUX_NEG_LO   = 4;
  localparam int MUX_POS_HI   = 3;
  localparam int MUX_POS_LO   = 0;

  // Edge flag indices inside the flag pair
  localparam int FLAG_FALL = 0;
  localparam int FLAG_RISE = 1;
  localparam int FLAG_NUM  = 2;

  // Hysteresis selections: none, 5 mV, 10 mV, 20 mV
  typedef enum logic [1:0] {
    HYST_NONE  = 2'h0,
    HYST_5MV   = 2'h1,
    HYST_10MV  = 2'h2,
    HYST_20MV  = 2'h3
  } ccl_hyst_type;

  // Software-writable fields of the control register
  typedef struct packed {
    logic         enable;
    ccl_hyst_type pos_hysteresis_sel;
    ccl_hyst_type neg_hysteresis_sel;
  } ccl_ctrl_type;

  // Mode register fields
  typedef struct packed {
    logic       rise_irq_enable;
    logic       fall_irq_enable;
    logic [1:0] response_mode;
  } ccl_mode_type;

  // Input mux fields
  typedef struct packed {
    logic [3:0] neg_input_select;
    logic [3:0] pos_input_select;
  } ccl_mux_type;

endpackage

/* hw/ccl_sync2.sv */
// Two-stage synchroniser for one level from outside the clock domain.
// Assumes the input may change at any time relative to the clock.
`timescale 1ns/1ps

module ccl_sync2 (
  input  wire logic i_clock,
  input  wire logic i_arst_n,
  input  wire logic i_async,
  output logic      o_sync
);

  logic meta;
  logic next_meta;
  logic next_sync;

  // ----------------------------------------------------------------
  // Stages
  // ----------------------------------------------------------------
  // First stage is read only by the second stage
  always_comb begin
    next_meta = i_async;
    next_sync = meta;
  end

  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      meta   <= 1'b0;
      o_sync <= 1'b0;
    end else begin
      meta   <= next_meta;
      o_sync <= next_sync;
    end
  end

endmodule

/* hw/ccl_top.sv */
// Comparator control logic: control/status registers, edge flags, outputs.
// Assumes an 8-bit register port from the core and a raw compare level from
// the analogue comparator core, which is asynchronous to I_CLOCK.
`timescale 1ns/1ps

module ccl_top (
  input  wire logic        I_CLOCK,
  input  wire logic        I_ARST_N,
  input  wire logic        I_RAW_COMPARE,
  input  wire logic [7:0]  I_SFR_ADDR,
  input  wire logic        I_SFR_WR,
  input  wire logic [7:0]  I_SFR_WDATA,
  input  wire logic        I_SYS_IRQ_ENABLE,
  input  wire logic        I_RESET_SRC_ENABLE,
  output logic      [7:0]  O_SFR_RDATA,
  output logic             O_RAW_COMPARE_OUT,
  output logic             O_LATCHED_COMPARE_OUT,
  output logic             O_IRQ,
  output logic             O_OSC_WAKE,
  output logic             O_RESET_REQ,
  output logic             O_COMP_ENABLE,
  output logic      [1:0]  O_POS_HYSTERESIS_SEL,
  output logic      [1:0]  O_NEG_HYSTERESIS_SEL,
  output logic      [1:0]  O_RESPONSE_MODE,
  output logic      [3:0]  O_NEG_INPUT_SELECT,
  output logic      [3:0]  O_POS_INPUT_SELECT
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  ccl_pkg::ccl_ctrl_type                ctrl;
  ccl_pkg::ccl_ctrl_type                next_ctrl;
  ccl_pkg::ccl_mode_type                mode;
  ccl_pkg::ccl_mode_type                next_mode;
  ccl_pkg::ccl_mux_type                 mux;
  ccl_pkg::ccl_mux_type                 next_mux;
  logic                                 cmp_sync;
  logic                                 cmp_prev;
  logic                                 next_cmp_prev;
  logic                                 armed;
  logic                                 next_armed;
  logic [ccl_pkg::FLAG_NUM-1:0]         edge_set;
  logic [ccl_pkg::FLAG_NUM-1:0]         flag;
  logic [ccl_pkg::FLAG_NUM-1:0]         flag_wdata;
  logic                                 wr_ctrl;
  logic                                 wr_mode;
  logic                                 wr_mux;
  logic                                 result;
  logic [7:0]                           ctrl_rd;
  logic [7:0]                           next_rdata;
  logic                                 next_latched;
  logic                                 next_irq;
  logic                                 next_wake;
  logic                                 next_reset_req;

  // ----------------------------------------------------------------
  // Raw compare path
  // ----------------------------------------------------------------
  // Unclocked raw output
  // Deliberately combinational so it survives a stopped clock; the only gate
  // is the enable, which holds its value while the clock is stopped.
  // Low when disabled
  assign O_RAW_COMPARE_OUT = ctrl.enable & I_RAW_COMPARE;

  ccl_sync2 u_sync (
    .i_clock  (I_CLOCK),
    .i_arst_n (I_ARST_N),
    .i_async  (I_RAW_COMPARE),
    .o_sync   (cmp_sync)
  );

  // ----------------------------------------------------------------
  // Edge detection
  // ----------------------------------------------------------------
  // Compare successive samples
  // Detection waits one cycle after enable, but the synchroniser takes two, so the first sample after power-up
  // is compared with the level from before enable and can set a flag; analogue settling glitches remain possible.
  always_comb begin
    next_cmp_prev = cmp_sync;
    next_armed    = ctrl.enable;
  end

  always_ff @(posedge I_CLOCK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      cmp_prev <= 1'b0;
      armed    <= 1'b0;
    end else begin
      cmp_prev <= next_cmp_prev;
      armed    <= next_armed;
    end
  end

  assign edge_set[ccl_pkg::FLAG_FALL] = armed & ctrl.enable & cmp_prev & ~cmp_sync;
  assign edge_set[ccl_pkg::FLAG_RISE] = armed & ctrl.enable & ~cmp_prev & cmp_sync;

  assign flag_wdata[ccl_pkg::FLAG_FALL] = I_SFR_WDATA[ccl_pkg::CTRL_FALL_BIT];
  assign flag_wdata[ccl_pkg::FLAG_RISE] = I_SFR_WDATA[ccl_pkg::CTRL_RISE_BIT];

  ccl_edge_flags u_flags (
    .i_clock  (I_CLOCK),
    .i_arst_n (I_ARST_N),
    .i_set    (edge_set),
    .i_wr     (wr_ctrl),
    .i_wdata  (flag_wdata),
    .o_flag   (flag)
  );

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  assign wr_ctrl = I_SFR_WR & (I_SFR_ADDR == ccl_pkg::CTRL_ADDR);
  assign wr_mode = I_SFR_WR & (I_SFR_ADDR == ccl_pkg::MODE_ADDR);
  assign wr_mux  = I_SFR_WR & (I_SFR_ADDR == ccl_pkg::MUX_ADDR);

  // Result bit is not writable; flags are handled in the flag module
  always_comb begin
    next_ctrl = ctrl;
    next_mode = mode;
    next_mux  = mux;
    if (wr_ctrl) begin
      next_ctrl.enable = I_SFR_WDATA[ccl_pkg::CTRL_EN_BIT];
      next_ctrl.pos_hysteresis_sel = ccl_pkg::ccl_hyst_type'(
        I_SFR_WDATA[ccl_pkg::CTRL_HYP_HI:ccl_pkg::CTRL_HYP_LO]);
      next_ctrl.neg_hysteresis_sel = ccl_pkg::ccl_hyst_type'(
        I_SFR_WDATA[ccl_pkg::CTRL_HYN_HI:ccl_pkg::CTRL_HYN_LO]);
    end
    if (wr_mode) begin
      next_mode.rise_irq_enable = I_SFR_WDATA[ccl_pkg::MODE_RIE_BIT];
      next_mode.fall_irq_enable = I_SFR_WDATA[ccl_pkg::MODE_FIE_BIT];
      next_mode.response_mode   = I_SFR_WDATA[ccl_pkg::MODE_MD_HI:ccl_pkg::MODE_MD_LO];
    end
    if (wr_mux) begin
      next_mux.neg_input_select = I_SFR_WDATA[ccl_pkg::MUX_NEG_HI:ccl_pkg::MUX_NEG_LO];
      next_mux.pos_input_select = I_SFR_WDATA[ccl_pkg::MUX_POS_HI:ccl_pkg::MUX_POS_LO];
    end
  end

  always_ff @(posedge I_CLOCK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      // Fields picked out of the register reset byte by position, not by width
      ctrl <= ccl_pkg::ccl_ctrl_type'({
        ccl_pkg::CTRL_RESET[ccl_pkg::CTRL_EN_BIT],
        ccl_pkg::CTRL_RESET[ccl_pkg::CTRL_HYP_HI:ccl_pkg::CTRL_HYN_LO]});
      mode <= ccl_pkg::ccl_mode_type'({
        ccl_pkg::MODE_RESET[ccl_pkg::MODE_RIE_BIT],
        ccl_pkg::MODE_RESET[ccl_pkg::MODE_FIE_BIT],
        ccl_pkg::MODE_RESET[ccl_pkg::MODE_MD_HI:ccl_pkg::MODE_MD_LO]});
      mux  <= ccl_pkg::ccl_mux_type'(ccl_pkg::MUX_RESET);
    end else begin
      ctrl <= next_ctrl;
      mode <= next_mode;
      mux  <= next_mux;
    end
  end

  // ----------------------------------------------------------------
  // Register reads and outputs
  // ----------------------------------------------------------------
  // One means positive above negative
  // A disabled comparator reports zero, matching its pin outputs.
  assign result = ctrl.enable & cmp_sync;

  always_comb begin
    ctrl_rd                          = ccl_pkg::ZERO_BYTE;
    ctrl_rd[ccl_pkg::CTRL_EN_BIT]    = ctrl.enable;
    ctrl_rd[ccl_pkg::CTRL_OUT_BIT]   = result;
    ctrl_rd[ccl_pkg::CTRL_RISE_BIT]  = flag[ccl_pkg::FLAG_RISE];
    ctrl_rd[ccl_pkg::CTRL_FALL_BIT]  = flag[ccl_pkg::FLAG_FALL];
    ctrl_rd[ccl_pkg::CTRL_HYP_HI:ccl_pkg::CTRL_HYP_LO] = ctrl.pos_hysteresis_sel;
    ctrl_rd[ccl_pkg::CTRL_HYN_HI:ccl_pkg::CTRL_HYN_LO] = ctrl.neg_hysteresis_sel;
  end

  // Read data follows the address with one cycle of latency
  always_comb begin
    next_rdata = ccl_pkg::ZERO_BYTE;
    case (I_SFR_ADDR)
      ccl_pkg::CTRL_ADDR: begin
        next_rdata = ctrl_rd;
      end
      ccl_pkg::MODE_ADDR: begin
        next_rdata[ccl_pkg::MODE_RIE_BIT] = mode.rise_irq_enable;
        next_rdata[ccl_pkg::MODE_FIE_BIT] = mode.fall_irq_enable;
        next_rdata[ccl_pkg::MODE_MD_HI:ccl_pkg::MODE_MD_LO] = mode.response_mode;
      end
      ccl_pkg::MUX_ADDR: begin
        next_rdata = mux;
      end
      default: begin
        next_rdata = ccl_pkg::ZERO_BYTE;
      end
    endcase
  end

  // Derived status outputs
  always_comb begin
    next_latched   = result;
    next_irq       = I_SYS_IRQ_ENABLE &
                     ((mode.rise_irq_enable & flag[ccl_pkg::FLAG_RISE]) |
                      (mode.fall_irq_enable & flag[ccl_pkg::FLAG_FALL]));
    next_wake      = ctrl.enable & ~cmp_sync;
    next_reset_req = I_RESET_SRC_ENABLE & ctrl.enable & ~cmp_sync;
  end

  always_ff @(posedge I_CLOCK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      O_SFR_RDATA           <= ccl_pkg::ZERO_BYTE;
      O_LATCHED_COMPARE_OUT <= 1'b0;
      O_IRQ                 <= 1'b0;
      O_OSC_WAKE            <= 1'b0;
      O_RESET_REQ           <= 1'b0;
      O_COMP_ENABLE         <= 1'b0;
      O_POS_HYSTERESIS_SEL  <= ccl_pkg::HYST_NONE;
      O_NEG_HYSTERESIS_SEL  <= ccl_pkg::HYST_NONE;
      O_RESPONSE_MODE       <= 2'(ccl_pkg::MODE_RESET);
      O_NEG_INPUT_SELECT    <= ccl_pkg::MUX_RESET[ccl_pkg::MUX_NEG_HI:ccl_pkg::MUX_NEG_LO];
      O_POS_INPUT_SELECT    <= ccl_pkg::MUX_RESET[ccl_pkg::MUX_POS_HI:ccl_pkg::MUX_POS_LO];
    end else begin
      O_SFR_RDATA           <= next_rdata;
      O_LATCHED_COMPARE_OUT <= next_latched;
      O_IRQ                 <= next_irq;
      O_OSC_WAKE            <= next_wake;
      O_RESET_REQ           <= next_reset_req;
      O_COMP_ENABLE         <= next_ctrl.enable;
      O_POS_HYSTERESIS_SEL  <= next_ctrl.pos_hysteresis_sel;
      O_NEG_HYSTERESIS_SEL  <= next_ctrl.neg_hysteresis_sel;
      O_RESPONSE_MODE       <= next_mode.response_mode;
      O_NEG_INPUT_SELECT    <= next_mux.neg_input_select;
      O_POS_INPUT_SELECT    <= next_mux.pos_input_select;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  // Falling edge check
  chk_fall_flag_set: assert property (@(posedge I_CLOCK) disable iff (!I_ARST_N)
    (armed && ctrl.enable && cmp_prev && !cmp_sync) |=> flag[ccl_pkg::FLAG_FALL])
    else $error("fall flag not set after falling edge");

  chk_rise_flag_set: assert property (@(posedge I_CLOCK) disable iff (!I_ARST_N)
    (armed && ctrl.enable && !cmp_prev && cmp_sync) |=> flag[ccl_pkg::FLAG_RISE])
    else $error("rise flag not set after rising edge");

  chk_flag_sticky: assert property (@(posedge I_CLOCK) disable iff (!I_ARST_N)
    (flag[ccl_pkg::FLAG_RISE] && !wr_ctrl) |=> flag[ccl_pkg::FLAG_RISE])
    else $error("rise flag dropped without a write");

  chk_flag_clear: assert property (@(posedge I_CLOCK) disable iff (!I_ARST_N)
    (wr_ctrl && !I_SFR_WDATA[ccl_pkg::CTRL_FALL_BIT] && !edge_set[ccl_pkg::FLAG_FALL])
    |=> !flag[ccl_pkg::FLAG_FALL])
    else $error("fall flag not cleared by zero write");

  chk_result_read: assert property (@(posedge I_CLOCK) disable iff (!I_ARST_N)
    (I_SFR_ADDR == ccl_pkg::CTRL_ADDR) |=>
    (O_SFR_RDATA[ccl_pkg::CTRL_OUT_BIT] == $past(ctrl.enable && cmp_sync)))
    else $error("result bit readback mismatch");

  chk_disabled_low: assert property (@(posedge I_CLOCK) disable iff (!I_ARST_N)
    !ctrl.enable |=> !O_LATCHED_COMPARE_OUT)
    else $error("latched output high while disabled");

  chk_osc_wake: assert property (@(posedge I_CLOCK) disable iff (!I_ARST_N)
    (ctrl.enable && !cmp_sync) |=> O_OSC_WAKE)
    else $error("oscillator wake missing");

  chk_irq_gate: assert property (@(posedge I_CLOCK) disable iff (!I_ARST_N)
    O_IRQ |-> $past(I_SYS_IRQ_ENABLE) &&
    ($past(mode.rise_irq_enable && flag[ccl_pkg::FLAG_RISE]) ||
     $past(mode.fall_irq_enable && flag[ccl_pkg::FLAG_FALL])))
    else $error("interrupt without enabled flag");

  chk_sync_delay: assert property (@(posedge I_CLOCK) disable iff (!I_ARST_N)
    (ctrl.enable && I_RAW_COMPARE) [*3] |-> ##1 O_LATCHED_COMPARE_OUT)
    else $error("latched output not high after sync delay");

  chk_enable_write: assert property (@(posedge I_CLOCK) disable iff (!I_ARST_N)
    wr_ctrl |=> (O_COMP_ENABLE == $past(I_SFR_WDATA[ccl_pkg::CTRL_EN_BIT])))
    else $error("enable bit write not reflected");

endmodule
